// *** src/lcc_cfg.svh ***
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH
// Behaviour
// RL1: idle-auto bit 5 low: output muting follows manual idle-select bit 4.
// RL2: manual idle: select 0 drives output with detect off, 1 mutes.
// RL3: rate-auto bit 1 low: rate range follows manual rate-select bit 0.
// RL4: manual rate: select 0 is 2.5-3.2 Gbps, 1 is 5.0-6.4 Gbps.
// RL5: idle/rate bits 7:6 and 3:2 reset to zero and ignore writes.
// RL6: equalizer gives 24 levels, three gain stages of eight boosts.
// RL7: equalizer bit 5 enables, bits 4:3 gain stage, bits 2:0 boost.
// RL8: equalizer resets to 20h, bypass with enable set.
// RL9: nine strap equalizer codes reproduce their strap setting when written.
// RL10: swing resets to 03h (600 mV); bits 7:6 read-only zero.
// RL11: swing codes 07h/0Fh/1Fh/3Fh give 800/1000/1200/1400 mV.
// RL12: de-emphasis bit 7 picks compatibility (0) or enhanced (1).
// RL13: de-emphasis bits 6:0 are the level; register resets to 03h.
// RL14: de-emphasis 01h/38h/88h/90h/A0h give 0/-3.5/-6/-9/-12 dB.
// RL15: software must never program reserved de-emphasis code C0h.
// RL16: idle threshold bits 3:2 de-assert, bits 1:0 assert, 7:4 reserved.
// RL17: threshold codes 00..11 give 110/70 up to 190/150 mV pairs.
// RL18: rate override low lets rate pin rule; high gives register control.
// RL19: idle override low lets idle pin rule; high gives register control.
// RL20: registers read back written bits; reserved bits read zero.
// RL21: a write reaches only this lane's analogue controls.

// -----------------------------------------------------------
// register offsets
// -----------------------------------------------------------
`define LCC_ADDR_IDLE_RATE 8'h15
`define LCC_ADDR_EQ        8'h16
`define LCC_ADDR_SWING     8'h17
`define LCC_ADDR_DEEMPH    8'h18
`define LCC_ADDR_THRESH    8'h19

// -----------------------------------------------------------
// writable masks and reset values
// -----------------------------------------------------------
`define LCC_MASK_IDLE_RATE 8'h33
`define LCC_MASK_EQ        8'h3F
`define LCC_MASK_SWING     8'h3F
`define LCC_MASK_DEEMPH    8'hFF
`define LCC_MASK_THRESH    8'h0F
`define LCC_RST_IDLE_RATE  8'h00
`define LCC_RST_EQ         8'h20
`define LCC_RST_SWING      8'h03
`define LCC_RST_DEEMPH     8'h03
`define LCC_RST_THRESH     8'h00

// -----------------------------------------------------------
// field positions
// -----------------------------------------------------------
`define LCC_IDLE_AUTO_BIT  5
`define LCC_IDLE_SEL_BIT   4
`define LCC_RATE_AUTO_BIT  1
`define LCC_RATE_SEL_BIT   0
`define LCC_EQ_EN_BIT      5
`define LCC_EQ_GST_MSB     4
`define LCC_EQ_GST_LSB     3
`define LCC_EQ_BST_MSB     2
`define LCC_DEEMPH_TYPE    7
`define LCC_DEEMPH_LVL_MSB 6
`define LCC_TH_DEA_MSB     3
`define LCC_TH_DEA_LSB     2
`define LCC_TH_AST_MSB     1
`define LCC_EQ_NUM_STAGES  2'h3

// -----------------------------------------------------------
// strap equalizer codes
// -----------------------------------------------------------
`define LCC_EQ_STRAP_CODES {8'h20, 8'h2A, 8'h30, 8'h31, 8'h38, \
                            8'h34, 8'h35, 8'h3A, 8'h3C}
`define LCC_EQ_NUM_STRAPS  9

// -----------------------------------------------------------
// swing and de-emphasis codes
// -----------------------------------------------------------
`define LCC_SW_600_CODE    6'h03
`define LCC_SW_800_CODE    6'h07
`define LCC_SW_1000_CODE   6'h0F
`define LCC_SW_1200_CODE   6'h1F
`define LCC_SW_1400_CODE   6'h3F
`define LCC_DE_0DB_CODE    8'h01
`define LCC_DE_3P5DB_CODE  8'h38
`define LCC_DE_6DB_CODE    8'h88
`define LCC_DE_9DB_CODE    8'h90
`define LCC_DE_12DB_CODE   8'hA0
`define LCC_DE_RSVD_CODE   8'hC0

// -----------------------------------------------------------
// idle thresholds in mV, index is the 2-bit code
// -----------------------------------------------------------
`define LCC_TH_DEA_MV {8'hBE, 8'hAA, 8'h96, 8'h6E}
`define LCC_TH_AST_MV {8'h96, 8'h82, 8'h6E, 8'h46}
`endif

// *** src/lcc_pkg.sv ***
package lcc_pkg;
  typedef logic [7:0] lcc_byte_t;

  // decoded driver swing, one-hot
  typedef enum logic [5:0] {
    LCC_SW_600   = 6'h01,
    LCC_SW_800   = 6'h02,
    LCC_SW_1000  = 6'h04,
    LCC_SW_1200  = 6'h08,
    LCC_SW_1400  = 6'h10,
    LCC_SW_OTHER = 6'h20
  } lcc_swing_e;

  // decoded de-emphasis setting, one-hot
  typedef enum logic [6:0] {
    LCC_DE_0DB   = 7'h01,
    LCC_DE_3P5DB = 7'h02,
    LCC_DE_6DB   = 7'h04,
    LCC_DE_9DB   = 7'h08,
    LCC_DE_12DB  = 7'h10,
    LCC_DE_RSVD  = 7'h20,
    LCC_DE_OTHER = 7'h40
  } lcc_deemph_e;
endpackage

// *** src/lcc_mode_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// register fields and pin levels in, resolved lane modes out
interface lcc_mode_if;
  logic idle_auto;
  logic idle_sel;
  logic rate_auto;
  logic rate_sel;
  logic idle_ovr;
  logic rate_ovr;
  logic idle_pin;
  logic rate_pin;
  logic idle_det;
  logic rate_det;
  logic mute;
  logic sd_en;
  logic rate_high;
  logic idle_auto_act;
  logic rate_auto_act;

  modport cfg (output idle_auto, idle_sel, rate_auto, rate_sel,
               idle_ovr, rate_ovr, idle_pin, rate_pin, idle_det, rate_det,
               input mute, sd_en, rate_high, idle_auto_act, rate_auto_act);
  modport sel (input idle_auto, idle_sel, rate_auto, rate_sel,
               idle_ovr, rate_ovr, idle_pin, rate_pin, idle_det, rate_det,
               output mute, sd_en, rate_high, idle_auto_act, rate_auto_act);
endinterface
`default_nettype wire

// *** src/lcc_sync2.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_sync2 #(
  parameter int W = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // two-stage synchroniser; only the second stage is read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** src/lcc_mode_sel.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_mode_sel (
  input wire logic mclk_i,
  input wire logic rst_i,
  lcc_mode_if.sel  m
);
  logic idle_auto_eff;
  logic rate_auto_eff;
  logic mute_next;
  logic rate_next;

  // override high hands control to the register, low to the pins
  always_comb begin
    idle_auto_eff = m.idle_ovr ? m.idle_auto : m.idle_pin;  // RL19 RL1
    mute_next     = idle_auto_eff ? m.idle_det
                                  : (m.idle_ovr & m.idle_sel);  // RL2
    rate_auto_eff = m.rate_ovr & m.rate_auto;  // RL3
    if (!m.rate_ovr) begin
      rate_next = m.rate_pin;  // RL18
    end else if (m.rate_auto) begin
      rate_next = m.rate_det;
    end else begin
      rate_next = m.rate_sel;  // RL4
    end
  end

  // registered so the analogue controls never see decode glitches
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      m.mute          <= 1'b0;
      m.sd_en         <= 1'b0;
      m.rate_high     <= 1'b0;
      m.idle_auto_act <= 1'b0;
      m.rate_auto_act <= 1'b0;
    end else begin
      m.mute          <= mute_next;
      m.sd_en         <= idle_auto_eff;
      m.rate_high     <= rate_next;
      m.idle_auto_act <= idle_auto_eff;
      m.rate_auto_act <= rate_auto_eff;
    end
  end
endmodule
`default_nettype wire

// *** src/lcc_lane_regs.sv ***
`include "lcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module lcc_lane_regs (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  // register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output var  logic [7:0]         reg_rdata_o,
  // global override bits, same clock
  input  wire logic               idle_override_i,
  input  wire logic               rate_override_i,
  // pins and analogue detectors, asynchronous
  input  wire logic               idle_pin_i,
  input  wire logic               rate_pin_i,
  input  wire logic               idle_detect_i,
  input  wire logic               rate_detect_i,
  // receive equalizer
  output var  logic               eq_enable_o,
  output var  logic [1:0]         gain_stage_o,
  output var  logic [2:0]         boost_level_o,
  output var  logic               eq_level_valid_o,
  output var  logic               eq_strap_match_o,
  // driver
  output var  logic [5:0]         output_swing_o,
  output var  lcc_pkg::lcc_swing_e  output_swing_level_o,
  output var  logic               tx_deemph_type_o,
  output var  logic [6:0]         tx_deemph_level_o,
  output var  lcc_pkg::lcc_deemph_e tx_deemph_setting_o,
  // idle detector
  output var  logic [1:0]         idle_deassert_sel_o,
  output var  logic [1:0]         idle_assert_sel_o,
  output var  logic [7:0]         idle_deassert_mv_o,
  output var  logic [7:0]         idle_assert_mv_o,
  // resolved lane modes
  output var  logic               output_mute_o,
  output var  logic               signal_detect_en_o,
  output var  logic               rate_high_o,
  output var  logic               idle_auto_active_o,
  output var  logic               rate_auto_active_o
);

  // -----------------------------------------------------------
  // storage
  // -----------------------------------------------------------
  lcc_pkg::lcc_byte_t idle_rate_reg;
  lcc_pkg::lcc_byte_t eq_reg;
  lcc_pkg::lcc_byte_t swing_reg;
  lcc_pkg::lcc_byte_t deemph_reg;
  lcc_pkg::lcc_byte_t thresh_reg;
  lcc_pkg::lcc_byte_t rdata_next;
  logic [3:0]         async_sync;

  lcc_mode_if m_if ();

  // -----------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------

  // masked write keeps reserved bits at zero
  function automatic lcc_pkg::lcc_byte_t wr_val(
    input lcc_pkg::lcc_byte_t d,
    input lcc_pkg::lcc_byte_t mask
  );
    wr_val = d & mask;
  endfunction

  // true when the equalizer code equals one of the strap settings
  function automatic logic is_strap(input lcc_pkg::lcc_byte_t code);
    logic [8*`LCC_EQ_NUM_STRAPS-1:0] tbl;
    tbl      = `LCC_EQ_STRAP_CODES;
    is_strap = 1'b0;
    for (int i = 0; i < `LCC_EQ_NUM_STRAPS; i++) begin
      if (tbl[8*i +: 8] == code) begin
        is_strap = 1'b1;
      end
    end
  endfunction

  // swing code to driver level; uncharted codes flagged
  function automatic lcc_pkg::lcc_swing_e swing_dec(input logic [5:0] c);
    case (c)
      `LCC_SW_600_CODE:  swing_dec = lcc_pkg::LCC_SW_600;
      `LCC_SW_800_CODE:  swing_dec = lcc_pkg::LCC_SW_800;
      `LCC_SW_1000_CODE: swing_dec = lcc_pkg::LCC_SW_1000;
      `LCC_SW_1200_CODE: swing_dec = lcc_pkg::LCC_SW_1200;
      `LCC_SW_1400_CODE: swing_dec = lcc_pkg::LCC_SW_1400;
      default:           swing_dec = lcc_pkg::LCC_SW_OTHER;
    endcase
  endfunction

  // de-emphasis code to setting; the reserved code is only flagged,
  // since keeping software off it is software's job
  function automatic lcc_pkg::lcc_deemph_e de_dec(input logic [7:0] c);
    case (c)
      `LCC_DE_0DB_CODE:   de_dec = lcc_pkg::LCC_DE_0DB;
      `LCC_DE_3P5DB_CODE: de_dec = lcc_pkg::LCC_DE_3P5DB;
      `LCC_DE_6DB_CODE:   de_dec = lcc_pkg::LCC_DE_6DB;
      `LCC_DE_9DB_CODE:   de_dec = lcc_pkg::LCC_DE_9DB;
      `LCC_DE_12DB_CODE:  de_dec = lcc_pkg::LCC_DE_12DB;
      `LCC_DE_RSVD_CODE:  de_dec = lcc_pkg::LCC_DE_RSVD;  // RL15
      default:            de_dec = lcc_pkg::LCC_DE_OTHER;
    endcase
  endfunction

  // 2-bit threshold code to millivolts from a 4-entry table
  function automatic logic [7:0] thr_mv(
    input logic [31:0] tbl,
    input logic [1:0]  code
  );
    thr_mv = tbl[8*code +: 8];
  endfunction

  // -----------------------------------------------------------
  // register writes, one process per register
  // -----------------------------------------------------------

  // idle and rate select
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_rate_reg <= `LCC_RST_IDLE_RATE;
    end else if (reg_wr_i && reg_addr_i == `LCC_ADDR_IDLE_RATE) begin
      idle_rate_reg <= wr_val(reg_wdata_i, `LCC_MASK_IDLE_RATE);  // RL5
    end
  end

  // receive equalizer, bypass after reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      eq_reg <= `LCC_RST_EQ;  // RL8
    end else if (reg_wr_i && reg_addr_i == `LCC_ADDR_EQ) begin
      eq_reg <= wr_val(reg_wdata_i, `LCC_MASK_EQ);  // RL9
    end
  end

  // driver swing, top bits stay zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      swing_reg <= `LCC_RST_SWING;  // RL10
    end else if (reg_wr_i && reg_addr_i == `LCC_ADDR_SWING) begin
      swing_reg <= wr_val(reg_wdata_i, `LCC_MASK_SWING);  // RL10
    end
  end

  // transmit de-emphasis, all eight bits live
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      deemph_reg <= `LCC_RST_DEEMPH;  // RL13
    end else if (reg_wr_i && reg_addr_i == `LCC_ADDR_DEEMPH) begin
      deemph_reg <= wr_val(reg_wdata_i, `LCC_MASK_DEEMPH);
    end
  end

  // idle detect thresholds
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thresh_reg <= `LCC_RST_THRESH;  // RL17
    end else if (reg_wr_i && reg_addr_i == `LCC_ADDR_THRESH) begin
      thresh_reg <= wr_val(reg_wdata_i, `LCC_MASK_THRESH);  // RL16
    end
  end

  // -----------------------------------------------------------
  // read path
  // -----------------------------------------------------------

  // unmapped offsets read zero; a read in the write cycle sees old data
  always_comb begin
    case (reg_addr_i)
      `LCC_ADDR_IDLE_RATE: rdata_next = idle_rate_reg;  // RL20
      `LCC_ADDR_EQ:        rdata_next = eq_reg;
      `LCC_ADDR_SWING:     rdata_next = swing_reg;
      `LCC_ADDR_DEEMPH:    rdata_next = deemph_reg;
      `LCC_ADDR_THRESH:    rdata_next = thresh_reg;
      default:             rdata_next = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;  // RL20
    end
  end

  // -----------------------------------------------------------
  // analogue controls, straight from this lane's flops
  // -----------------------------------------------------------

  // each field is wired only from its own register
  assign eq_enable_o    = eq_reg[`LCC_EQ_EN_BIT];  // RL7 RL21
  assign gain_stage_o   = eq_reg[`LCC_EQ_GST_MSB:`LCC_EQ_GST_LSB];  // RL7
  assign boost_level_o  = eq_reg[`LCC_EQ_BST_MSB:0];  // RL7
  assign output_swing_o = swing_reg[5:0];
  assign tx_deemph_type_o  = deemph_reg[`LCC_DEEMPH_TYPE];  // RL12
  assign tx_deemph_level_o = deemph_reg[`LCC_DEEMPH_LVL_MSB:0];  // RL13
  assign idle_deassert_sel_o =
    thresh_reg[`LCC_TH_DEA_MSB:`LCC_TH_DEA_LSB];  // RL16
  assign idle_assert_sel_o = thresh_reg[`LCC_TH_AST_MSB:0];  // RL16

  // stage 0 holds only bypass; stages 1..3 give the 3 x 8 = 24 levels
  assign eq_level_valid_o = gain_stage_o != 2'h0 || boost_level_o == 3'h0;  // RL6
  assign eq_strap_match_o = is_strap(eq_reg);  // RL9

  // decoded levels for the driver and the idle comparator
  assign output_swing_level_o = swing_dec(swing_reg[5:0]);  // RL11
  assign tx_deemph_setting_o  = de_dec(deemph_reg);  // RL14
  assign idle_deassert_mv_o =
    thr_mv(`LCC_TH_DEA_MV, idle_deassert_sel_o);  // RL17
  assign idle_assert_mv_o = thr_mv(`LCC_TH_AST_MV, idle_assert_sel_o);

  // -----------------------------------------------------------
  // pin and detector inputs, idle and rate resolution
  // -----------------------------------------------------------

  // all four are foreign to mclk_i, so they are synchronised together
  lcc_sync2 #(
    .W (4)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({idle_pin_i, rate_pin_i, idle_detect_i, rate_detect_i}),
    .q_o    (async_sync)
  );

  // register fields and overrides into the mode selector
  assign m_if.idle_auto = idle_rate_reg[`LCC_IDLE_AUTO_BIT];
  assign m_if.idle_sel  = idle_rate_reg[`LCC_IDLE_SEL_BIT];
  assign m_if.rate_auto = idle_rate_reg[`LCC_RATE_AUTO_BIT];
  assign m_if.rate_sel  = idle_rate_reg[`LCC_RATE_SEL_BIT];
  assign m_if.idle_ovr  = idle_override_i;
  assign m_if.rate_ovr  = rate_override_i;
  assign m_if.idle_pin  = async_sync[3];
  assign m_if.rate_pin  = async_sync[2];
  assign m_if.idle_det  = async_sync[1];
  assign m_if.rate_det  = async_sync[0];

  lcc_mode_sel u_mode (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .m      (m_if.sel)
  );

  assign output_mute_o      = m_if.mute;
  assign signal_detect_en_o = m_if.sd_en;
  assign rate_high_o        = m_if.rate_high;
  assign idle_auto_active_o = m_if.idle_auto_act;
  assign rate_auto_active_o = m_if.rate_auto_act;

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------

  sequence idle_manual_s;
    idle_override_i && !m_if.idle_auto;
  endsequence

  sequence rate_manual_s;
    rate_override_i && !m_if.rate_auto;
  endsequence

  sequence eq_wr_s;
    reg_wr_i && reg_addr_i == `LCC_ADDR_EQ;
  endsequence

  sequence wr_then_rd_s;
    eq_wr_s ##1 !reg_wr_i ##1 reg_rd_i && !reg_wr_i
      && reg_addr_i == `LCC_ADDR_EQ;
  endsequence

  idle_manual_a: assert property (  // RL2
    @(posedge mclk_i) disable iff (rst_i)
    idle_manual_s |=> output_mute_o == $past(m_if.idle_sel)
      && !signal_detect_en_o)
    else $error("manual idle select not applied");

  idle_auto_a: assert property (  // RL1
    @(posedge mclk_i) disable iff (rst_i)
    idle_override_i && m_if.idle_auto
      |=> signal_detect_en_o && output_mute_o == $past(m_if.idle_det))
    else $error("automatic idle not applied");

  idle_pin_a: assert property (  // RL19
    @(posedge mclk_i) disable iff (rst_i)
    !idle_override_i |=> signal_detect_en_o == $past(m_if.idle_pin))
    else $error("idle pin not in control");

  rate_manual_a: assert property (  // RL4
    @(posedge mclk_i) disable iff (rst_i)
    rate_manual_s |=> rate_high_o == $past(m_if.rate_sel)
      && !rate_auto_active_o)
    else $error("manual rate select not applied");

  rate_pin_a: assert property (  // RL18
    @(posedge mclk_i) disable iff (rst_i)
    !rate_override_i |=> rate_high_o == $past(m_if.rate_pin))
    else $error("rate pin not in control");

  reset_values_a: assert property (  // RL8
    @(posedge mclk_i) disable iff (rst_i)
    $past(rst_i) |-> eq_reg == 8'h20 && swing_reg == 8'h03
      && deemph_reg == 8'h03 && thresh_reg == 8'h00)
    else $error("wrong reset value");

  resv_zero_a: assert property (  // RL5
    @(posedge mclk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == `LCC_ADDR_IDLE_RATE
      |=> idle_rate_reg == ($past(reg_wdata_i) & 8'h33))
    else $error("reserved idle/rate bits not cleared");

  eq_fields_a: assert property (  // RL7
    @(posedge mclk_i) disable iff (rst_i)
    eq_wr_s |=> eq_enable_o == $past(reg_wdata_i[5])
      && gain_stage_o == $past(reg_wdata_i[4:3])
      && $stable(swing_reg) && $stable(deemph_reg))
    else $error("equalizer write misplaced");

  readback_a: assert property (  // RL20
    @(posedge mclk_i) disable iff (rst_i)
    wr_then_rd_s |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3F))
    else $error("read back differs");

  swing_map_a: assert property (  // RL11
    @(posedge mclk_i) disable iff (rst_i)
    swing_reg == 8'h1F |-> output_swing_level_o == lcc_pkg::LCC_SW_1200)
    else $error("swing 1Fh not decoded as 1200 mV");

  deemph_map_a: assert property (  // RL14
    @(posedge mclk_i) disable iff (rst_i)
    deemph_reg == 8'hA0 |-> tx_deemph_setting_o == lcc_pkg::LCC_DE_12DB)
    else $error("de-emphasis A0h not decoded as -12 dB");

  thresh_map_a: assert property (  // RL17
    @(posedge mclk_i) disable iff (rst_i)
    thresh_reg == 8'h0C |-> idle_deassert_mv_o == 8'hBE
      && idle_assert_mv_o == 8'h46)
    else $error("threshold 11/00 not 190/70 mV");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  // ---------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------
  int                   num_errors = 0;
  int                   checked    = 0;
  logic                 mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic                 idle_override_i = 1'b0, rate_override_i = 1'b0;
  logic                 idle_pin_i = 1'b0, rate_pin_i = 1'b0;
  logic                 idle_detect_i = 1'b0, rate_detect_i = 1'b0;
  logic [7:0]           reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd_val;
  logic                 eq_enable_o, eq_level_valid_o, eq_strap_match_o, tx_deemph_type_o;
  logic [1:0]           gain_stage_o, idle_deassert_sel_o, idle_assert_sel_o;
  logic [2:0]           boost_level_o;
  logic [5:0]           output_swing_o;
  logic [6:0]           tx_deemph_level_o;
  logic [7:0]           idle_deassert_mv_o, idle_assert_mv_o;
  lcc_pkg::lcc_swing_e  output_swing_level_o;
  lcc_pkg::lcc_deemph_e tx_deemph_setting_o;
  logic                 output_mute_o, signal_detect_en_o, rate_high_o;
  logic                 idle_auto_active_o, rate_auto_active_o;

  lcc_lane_regs i_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .idle_override_i, .rate_override_i, .idle_pin_i, .rate_pin_i,
    .idle_detect_i, .rate_detect_i, .eq_enable_o, .gain_stage_o, .boost_level_o,
    .eq_level_valid_o, .eq_strap_match_o, .output_swing_o, .output_swing_level_o,
    .tx_deemph_type_o, .tx_deemph_level_o, .tx_deemph_setting_o, .idle_deassert_sel_o,
    .idle_assert_sel_o, .idle_deassert_mv_o, .idle_assert_mv_o, .output_mute_o,
    .signal_detect_en_o, .rate_high_o, .idle_auto_active_o, .rate_auto_active_o);

  // 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------
  // bus cycles, inputs change 1 ns after the edge
  // ---------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_i = 1'b0;
    rd_val = reg_rdata_o;
  endtask

  // mode path needs 3 cycles from the pins, so 4 covers every source
  task automatic settle();
    repeat (4) @(posedge mclk_i);
    #1;
  endtask

  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  task automatic t_reset();
    logic [7:0] rv [5];
    rv = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(8'h15 + 8'(i));
      `CHK(rd_val, rv[i]);
    end
    rd(8'h1A);
    `CHK(rd_val, 8'h00);
    `CHK(idle_deassert_mv_o, 8'd110);
    `CHK(output_swing_level_o, lcc_pkg::LCC_SW_600);
    $display("test reset done");
  endtask

  task automatic t_eq();
    logic [7:0] ec [9];
    ec = '{8'h20, 8'h2A, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35, 8'h3A, 8'h3C};
    for (int i = 0; i < 9; i++) begin
      wr(8'h16, ec[i]);
      `CHK({eq_enable_o, gain_stage_o, boost_level_o}, ec[i][5:0]);
      `CHK(eq_strap_match_o, 1'b1);
      `CHK(eq_level_valid_o, 1'b1);
    end
    // gain stage 0 holds only bypass, and 27h is no strap code
    wr(8'h16, 8'hE7);
    `CHK(eq_level_valid_o, 1'b0);
    `CHK(eq_strap_match_o, 1'b0);
    rd(8'h16);
    `CHK(rd_val, 8'h27);
    $display("test equalizer done");
  endtask

  task automatic t_swing();
    logic [7:0] sc [6];
    sc = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h01};
    for (int i = 0; i < 6; i++) begin
      wr(8'h17, sc[i] | 8'hC0);
      `CHK(output_swing_o, sc[i][5:0]);
      `CHK(output_swing_level_o, 6'h01 << i);
      rd(8'h17);
      `CHK(rd_val, sc[i]);
    end
    `CHK(eq_enable_o, 1'b1);
    $display("test swing done");
  endtask

  task automatic t_deemph();
    logic [7:0] dc [7];
    // software keeps clear of the reserved code, so C1h stands in
    dc = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hC1, 8'h05};
    for (int i = 0; i < 7; i++) begin
      wr(8'h18, dc[i]);
      `CHK(tx_deemph_type_o, dc[i][7]);
      `CHK(tx_deemph_level_o, dc[i][6:0]);
      `CHK(tx_deemph_setting_o, (i < 5) ? 7'h01 << i : 7'h40);
      rd(8'h18);
      `CHK(rd_val, dc[i]);
    end
    $display("test deemphasis done");
  endtask

  task automatic t_thresh();
    logic [7:0] dmv [4];
    logic [7:0] amv [4];
    dmv = '{8'd110, 8'd150, 8'd170, 8'd190};
    amv = '{8'd70, 8'd110, 8'd130, 8'd150};
    // opposite codes in the two fields expose a swapped field
    for (int i = 0; i < 4; i++) begin
      wr(8'h19, {4'hF, 2'(i), 2'(3 - i)});
      `CHK(idle_deassert_sel_o, 2'(i));
      `CHK(idle_assert_sel_o, 2'(3 - i));
      `CHK(idle_deassert_mv_o, dmv[i]);
      `CHK(idle_assert_mv_o, amv[3 - i]);
      rd(8'h19);
      `CHK(rd_val, {4'h0, 2'(i), 2'(3 - i)});
    end
    $display("test threshold done");
  endtask

  task automatic t_mode();
    idle_override_i = 1'b1;
    rate_override_i = 1'b1;
    wr(8'h15, 8'hFF);
    rd(8'h15);
    `CHK(rd_val, 8'h33);
    wr(8'h15, 8'h11);
    settle();
    `CHK({output_mute_o, signal_detect_en_o, rate_high_o}, 3'b101);
    wr(8'h15, 8'h00);
    settle();
    `CHK({output_mute_o, signal_detect_en_o, rate_high_o}, 3'b000);
    idle_detect_i = 1'b1;
    rate_detect_i = 1'b1;
    wr(8'h15, 8'h22);
    settle();
    `CHK({output_mute_o, signal_detect_en_o, idle_auto_active_o}, 3'b111);
    `CHK({rate_high_o, rate_auto_active_o}, 2'b11);
    idle_detect_i = 1'b0;
    settle();
    `CHK(output_mute_o, 1'b0);
    // pins take over once the overrides drop
    idle_override_i = 1'b0;
    rate_override_i = 1'b0;
    settle();
    `CHK({signal_detect_en_o, rate_high_o, rate_auto_active_o}, 3'b000);
    idle_pin_i = 1'b1;
    rate_pin_i = 1'b1;
    rate_detect_i = 1'b0;
    settle();
    `CHK({signal_detect_en_o, rate_high_o}, 2'b11);
    $display("test mode done");
  endtask

  // ---------------------------------------------------------
  // verdict
  // ---------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    #40000;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_eq();
    t_swing();
    t_deemph();
    t_thresh();
    t_mode();
    final_report();
  end
endmodule
`default_nettype wire
